/* sms_buf2.sv */
// Two-entry first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`include "sms_consts.svh"
module sms_buf2 #(
	parameter int WIDTH = `SMS_BITS,
	parameter int DEPTH = `SMS_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// Fill side
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	// Drain side
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic [WIDTH-1:0]      o_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	assign o_ready = (count != FULL_CNT);
	assign o_valid = (count != '0);
	assign o_data  = mem[rd_ptr];

	always_comb
	begin
		push        = i_valid & o_ready;
		pop         = o_valid & i_ready;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		next_mem    = mem;
		if (push)
		begin
			next_mem[wr_ptr] = i_data;
			next_wr_ptr      = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop)
		begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push & ~pop)
		begin
			next_count = count + 1'b1;
		end
		else if (pop & ~push)
		begin
			next_count = count - 1'b1;
		end
	end

	generate
		for (genvar e = 0; e < DEPTH; e++)
		begin : g_entry
			always_ff @(posedge i_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					mem[e] <= '0;
				end
				else
				begin
					mem[e] <= next_mem[e];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end
endmodule // sms_buf2

/* sms_consts.svh */
// Constants for the serial shifter: widths, counts and timing limits.
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH
`define SMS_BITS       8
`define SMS_EDGES      5'd16
`define SMS_CNT_W      5
`define SMS_HALF_MIN   8'h07
`define SMS_BUF_DEPTH  2
`define SMS_PIN_SCK    0
`define SMS_PIN_MOSI   1
`define SMS_PIN_MISO   2
`define SMS_PIN_SS     3
`define SMS_NPINS      4
`define SMS_IDLE_BYTE  8'h00
`endif

/* sms_far_master.sv */
// Behavioural serial master that drives the shifter's link while it runs as a slave.
`timescale 1ns/1ps
module sms_far_master (
	// Transfer format
	input  wire logic clock_polarity,
	input  wire logic clock_phase,
	input  wire logic lsb,
	// Link
	output logic      sck,
	output logic      mosi,
	output logic      ss_n,
	input  wire logic miso
);
	localparam realtime HALF = 62.5;
	logic tog = 1'b0;
	initial
	begin
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	// The clock stands at its idle level between frames, so it follows polarity.
	assign sck = clock_polarity ^ tog;
	function automatic int idx(input int i);
		return lsb ? i : 7 - i;
	endfunction
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int i;
		ss_n = 1'b0;
		if (!clock_phase)
			mosi = tx[idx(0)];
		#HALF;
		for (i = 0; i < 8; i++)
		begin
			if (clock_phase)
				mosi = tx[idx(i)];
			tog = 1'b1;
			if (!clock_phase)
				rx[idx(i)] = miso;
			#HALF;
			tog = 1'b0;
			if (clock_phase)
				rx[idx(i)] = miso;
			else if (i < 7)
				mosi = tx[idx(i + 1)];
			#HALF;
		end
		ss_n = 1'b1;
		// A released data line must not keep showing the last bit.
		mosi = ~mosi;
		#(2 * HALF);
	endtask
endmodule // sms_far_master

/* sms_pkg.sv */
// Types shared by the serial shifter modules.
package sms_pkg;
	typedef enum logic [2:0] {
		SMS_IDLE,
		SMS_LEAD,
		SMS_XFER,
		SMS_TRAIL,
		SMS_GAP
	} sms_mstate_t;
endpackage

/* sms_shifter.sv */
// Serial peripheral shifter for master or slave use, with pin control and buffering.
`timescale 1ns/1ps
`include "sms_consts.svh"
module sms_shifter (
	// Clock and reset
	input  wire logic                 I_CLK,
	input  wire logic                 I_RST_N,
	// Configuration
	input  wire logic                 I_MODULE_ENABLE,
	input  wire logic                 I_MASTER_MODE,
	input  wire logic                 I_CLOCK_POLARITY,
	input  wire logic                 I_CLOCK_PHASE,
	input  wire logic                 I_BIT_ORDER_SELECT,
	input  wire logic                 I_MODE_FAULT_ENABLE,
	input  wire logic                 I_SELECT_OUTPUT_ENABLE,
	input  wire logic                 I_SINGLE_WIRE_SELECT,
	input  wire logic                 I_BIDIR_OUTPUT_ENABLE,
	input  wire logic [7:0]           I_BAUD_DIV,
	// Transmit data
	input  wire logic [`SMS_BITS-1:0] I_TX_DATA,
	input  wire logic                 I_TX_VALID,
	output logic                      O_TX_READY,
	// Receive data
	output logic [`SMS_BITS-1:0]      O_RX_DATA,
	output logic                      O_RX_VALID,
	input  wire logic                 I_RX_READY,
	// Status
	output logic                      O_BUSY,
	output logic                      O_RX_OVERRUN,
	// Serial clock pin
	input  wire logic                 I_SERIAL_CLOCK_PIN,
	output logic                      O_SERIAL_CLOCK_PIN,
	output logic                      O_SERIAL_CLOCK_PIN_OE_N,
	// Master out pin
	input  wire logic                 I_MASTER_OUT_PIN,
	output logic                      O_MASTER_OUT_PIN,
	output logic                      O_MASTER_OUT_PIN_OE_N,
	// Master in pin
	input  wire logic                 I_MASTER_IN_PIN,
	output logic                      O_MASTER_IN_PIN,
	output logic                      O_MASTER_IN_PIN_OE_N,
	// Slave select pin
	input  wire logic                 I_SLAVE_SELECT_PIN_N,
	output logic                      O_SLAVE_SELECT_PIN_N,
	output logic                      O_SLAVE_SELECT_PIN_OE_N
);
	logic [`SMS_NPINS-1:0] sync1;
	logic [`SMS_NPINS-1:0] sync2;
	logic                  sck_q;
	logic                  ss_act_q;
	sms_pkg::sms_mstate_t  state;
	sms_pkg::sms_mstate_t  next_state;
	logic [7:0]            div_cnt;
	logic [7:0]            next_div_cnt;
	logic [`SMS_CNT_W-1:0] cnt;
	logic [`SMS_CNT_W-1:0] next_cnt;
	logic [`SMS_BITS-1:0]  sh;
	logic [`SMS_BITS-1:0]  next_sh;
	logic                  rbit;
	logic                  next_rbit;
	logic                  sck_lvl;
	logic                  next_sck_lvl;
	logic                  s_run;
	logic                  next_s_run;
	logic [`SMS_BITS-1:0]  tx_hold;
	logic [`SMS_BITS-1:0]  next_tx_hold;
	logic                  tx_full;
	logic                  next_tx_full;
	logic                  data_q;
	logic                  overrun;
	logic                  is_master;
	logic                  ss_act;
	logic                  ss_fall;
	logic                  tick;
	logic                  ev;
	logic                  in_bit;
	logic                  take;
	logic                  done;
	logic                  rx_ready;
	logic [7:0]            half_len;
	logic [`SMS_CNT_W-1:0] k;

	function automatic logic [`SMS_BITS-1:0] shift_in(input logic [`SMS_BITS-1:0] v,
		input logic b, input logic lsb_first);
		shift_in = lsb_first ? {b, v[`SMS_BITS-1:1]} : {v[`SMS_BITS-2:0], b};
	endfunction

	// Pins cross into this clock domain through two flops before use.
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sync1 <= 4'hF;
			sync2 <= 4'hF;
		end
		else
		begin
			sync1 <= {I_SLAVE_SELECT_PIN_N, I_MASTER_IN_PIN, I_MASTER_OUT_PIN,
				I_SERIAL_CLOCK_PIN};
			sync2 <= sync1;
		end
	end

	assign is_master = I_MODULE_ENABLE & I_MASTER_MODE;
	assign ss_act    = I_MODULE_ENABLE & ~I_MASTER_MODE & ~sync2[`SMS_PIN_SS];
	assign ss_fall   = ss_act & ~ss_act_q;
	// The half period has a floor so that the far end's answer survives two synchronisers.
	assign half_len  = (I_BAUD_DIV < `SMS_HALF_MIN) ? `SMS_HALF_MIN : I_BAUD_DIV;
	assign tick      = (state != sms_pkg::SMS_IDLE) & (div_cnt == half_len);
	assign ev        = is_master ? ((state == sms_pkg::SMS_XFER) & tick)
		: (s_run & ~ss_fall & (sync2[`SMS_PIN_SCK] ^ sck_q));
	assign k         = cnt + 1'b1;
	assign in_bit    = is_master
		? (I_SINGLE_WIRE_SELECT ? sync2[`SMS_PIN_MOSI] : sync2[`SMS_PIN_MISO])
		: (I_SINGLE_WIRE_SELECT ? sync2[`SMS_PIN_MISO] : sync2[`SMS_PIN_MOSI]);
	assign O_TX_READY = ~tx_full;
	assign O_BUSY     = (state != sms_pkg::SMS_IDLE) | s_run;

	always_comb
	begin
		next_state   = state;
		next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
		next_cnt     = cnt;
		next_sh      = sh;
		next_rbit    = rbit;
		next_sck_lvl = sck_lvl;
		next_s_run   = s_run & ss_act;
		take         = 1'b0;
		done         = 1'b0;
		if (ev)
		begin
			next_cnt = k;
			// Phase zero samples on odd edges; phase one on even ones.
			if (I_CLOCK_PHASE ? ~k[0] : k[0])
			begin
				next_rbit = in_bit;
			end
			if (I_CLOCK_PHASE ? (k[0] & (k != 5'd1)) : ~k[0])
			begin
				next_sh = shift_in(sh, rbit, I_BIT_ORDER_SELECT);
			end
			if (k == `SMS_EDGES)
			begin
				if (I_CLOCK_PHASE)
				begin
					next_sh = shift_in(sh, in_bit, I_BIT_ORDER_SELECT);
				end
				done       = 1'b1;
				next_s_run = 1'b0;
			end
		end
		case (state)
			sms_pkg::SMS_IDLE:
			begin
				next_div_cnt = 8'h00;
				next_sck_lvl = 1'b0;
				if (is_master & tx_full & rx_ready)
				begin
					next_sh    = tx_hold;
					take       = 1'b1;
					next_cnt   = '0;
					next_state = sms_pkg::SMS_LEAD;
				end
			end
			sms_pkg::SMS_LEAD:
			begin
				if (tick)
				begin
					next_state = sms_pkg::SMS_XFER;
				end
			end
			sms_pkg::SMS_XFER:
			begin
				if (tick)
				begin
					next_sck_lvl = ~sck_lvl;
					if (k == `SMS_EDGES)
					begin
						next_state = sms_pkg::SMS_TRAIL;
					end
				end
			end
			sms_pkg::SMS_TRAIL:
			begin
				if (tick)
				begin
					next_state = sms_pkg::SMS_GAP;
				end
			end
			sms_pkg::SMS_GAP:
			begin
				if (tick)
				begin
					next_state = sms_pkg::SMS_IDLE;
				end
			end
			default:
			begin
				next_state = sms_pkg::SMS_IDLE;
			end
		endcase
		if (ss_fall)
		begin
			next_sh    = tx_full ? tx_hold : `SMS_IDLE_BYTE;
			take       = tx_full;
			next_cnt   = '0;
			next_s_run = 1'b1;
		end
		if (!is_master)
		begin
			next_state   = sms_pkg::SMS_IDLE;
			next_sck_lvl = 1'b0;
		end
		next_tx_full = (tx_full & ~take) | (I_TX_VALID & ~tx_full);
		next_tx_hold = (I_TX_VALID & ~tx_full) ? I_TX_DATA : tx_hold;
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			state    <= sms_pkg::SMS_IDLE;
			div_cnt  <= 8'h00;
			cnt      <= '0;
			sh       <= 8'h00;
			rbit     <= 1'b0;
			sck_lvl  <= 1'b0;
			s_run    <= 1'b0;
			tx_hold  <= 8'h00;
			tx_full  <= 1'b0;
			sck_q    <= 1'b1;
			ss_act_q <= 1'b0;
			data_q   <= 1'b0;
			overrun  <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			div_cnt  <= next_div_cnt;
			cnt      <= next_cnt;
			sh       <= next_sh;
			rbit     <= next_rbit;
			sck_lvl  <= next_sck_lvl;
			s_run    <= next_s_run;
			tx_hold  <= next_tx_hold;
			tx_full  <= next_tx_full;
			sck_q    <= sync2[`SMS_PIN_SCK];
			ss_act_q <= ss_act;
			data_q   <= I_BIT_ORDER_SELECT ? next_sh[0] : next_sh[`SMS_BITS-1];
			overrun  <= done & ~rx_ready;
		end
	end

	// Received words queue here; a full queue holds the master back, a slave cannot wait.
	sms_buf2 #(
		.WIDTH (`SMS_BITS),
		.DEPTH (`SMS_BUF_DEPTH)
	) u_rx_buf (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_valid (done),
		.o_ready (rx_ready),
		.i_data  (next_sh),
		.o_valid (O_RX_VALID),
		.i_ready (I_RX_READY),
		.o_data  (O_RX_DATA)
	);

	assign O_RX_OVERRUN            = overrun;
	assign O_SERIAL_CLOCK_PIN      = sck_lvl ^ I_CLOCK_POLARITY;
	assign O_SERIAL_CLOCK_PIN_OE_N = ~is_master;
	assign O_MASTER_OUT_PIN        = data_q;
	assign O_MASTER_OUT_PIN_OE_N   = ~(is_master & (~I_SINGLE_WIRE_SELECT | I_BIDIR_OUTPUT_ENABLE));
	assign O_MASTER_IN_PIN         = data_q;
	assign O_MASTER_IN_PIN_OE_N    = ~(ss_act & (~I_SINGLE_WIRE_SELECT | I_BIDIR_OUTPUT_ENABLE));
	assign O_SLAVE_SELECT_PIN_N    = ~((state == sms_pkg::SMS_LEAD) | (state == sms_pkg::SMS_XFER)
		| (state == sms_pkg::SMS_TRAIL));
	assign O_SLAVE_SELECT_PIN_OE_N = ~(is_master & I_MODE_FAULT_ENABLE & I_SELECT_OUTPUT_ENABLE);

	a_pins_released: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!I_MODULE_ENABLE |-> (O_SERIAL_CLOCK_PIN_OE_N & O_MASTER_OUT_PIN_OE_N
		& O_MASTER_IN_PIN_OE_N & O_SLAVE_SELECT_PIN_OE_N))
		else $error("pins driven while disabled");
	a_idle_clock_level: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(is_master && state == sms_pkg::SMS_IDLE) |-> (O_SERIAL_CLOCK_PIN == I_CLOCK_POLARITY))
		else $error("clock not idle between transfers");
	a_select_low_xfer: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state == sms_pkg::SMS_XFER) |-> !O_SLAVE_SELECT_PIN_N)
		else $error("select high during transfer");
	a_lead_half_period: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state == sms_pkg::SMS_IDLE ##1 state == sms_pkg::SMS_LEAD) |->
		(state == sms_pkg::SMS_LEAD) [*7])
		else $error("lead shorter than half period");
	a_sixteen_edges: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		($rose(state == sms_pkg::SMS_TRAIL)) |-> ($past(cnt) == 5'd15 && cnt == 5'd16))
		else $error("transfer did not end at sixteenth edge");
	a_gap_select_high: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state == sms_pkg::SMS_GAP) |-> O_SLAVE_SELECT_PIN_N)
		else $error("select not high between transfers");
	a_slave_no_clock: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_MODULE_ENABLE && !I_MASTER_MODE) |-> O_SERIAL_CLOCK_PIN_OE_N)
		else $error("slave drives serial clock");
	a_slave_needs_sel: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!ss_act |=> !s_run)
		else $error("slave active without select");
	a_tx_take_start: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state == sms_pkg::SMS_IDLE && is_master && tx_full && rx_ready) |=>
		(state == sms_pkg::SMS_LEAD && sh == $past(tx_hold) && !tx_full))
		else $error("queued word not loaded at start");
endmodule // sms_shifter

/* spi_master_slave_shifter_tb.sv */
// Self-checking testbench for the serial shifter in slave and master use.
`timescale 1ns/1ps
module spi_master_slave_shifter_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b1;
	logic mst = 1'b0;
	logic clock_polarity = 1'b0;
	logic clock_phase = 1'b0;
	logic lsb = 1'b0;
	logic mfe = 1'b0;
	logic select_output_enable = 1'b0;
	logic swire = 1'b0;
	logic bidir = 1'b0;
	logic [7:0] div = 8'h0F;
	logic [7:0] txd = 8'h00;
	logic txv = 1'b0;
	logic rxr = 1'b1;
	logic txr, rxv, busy, ovr, o_sck, sck_oe_n, o_mo, mo_oe_n, o_mi, mi_oe_n, o_ss, ss_oe_n;
	logic [7:0] rxd;
	wire sck, mosi, ss_n, miso;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n_ovr = 0;
	int seed;
	logic [7:0] q[$];
	logic [7:0] a, b, m, r;
	// The slave data line has a pull-up while nobody drives it.
	assign miso = mi_oe_n ? 1'b1 : o_mi;
	always #2 clk = ~clk;
	sms_far_master far (.clock_polarity(clock_polarity), .clock_phase(clock_phase), .lsb(lsb), .sck(sck), .mosi(mosi),
		.ss_n(ss_n), .miso(miso));
	sms_shifter DUT (
		.I_CLK(clk), .I_RST_N(rst_n), .I_MODULE_ENABLE(en), .I_MASTER_MODE(mst),
		.I_CLOCK_POLARITY(clock_polarity), .I_CLOCK_PHASE(clock_phase), .I_BIT_ORDER_SELECT(lsb),
		.I_MODE_FAULT_ENABLE(mfe), .I_SELECT_OUTPUT_ENABLE(select_output_enable),
		.I_SINGLE_WIRE_SELECT(swire), .I_BIDIR_OUTPUT_ENABLE(bidir), .I_BAUD_DIV(div),
		.I_TX_DATA(txd), .I_TX_VALID(txv), .O_TX_READY(txr), .O_RX_DATA(rxd),
		.O_RX_VALID(rxv), .I_RX_READY(rxr), .O_BUSY(busy), .O_RX_OVERRUN(ovr),
		.I_SERIAL_CLOCK_PIN(sck), .O_SERIAL_CLOCK_PIN(o_sck),
		.O_SERIAL_CLOCK_PIN_OE_N(sck_oe_n), .I_MASTER_OUT_PIN(mosi),
		.O_MASTER_OUT_PIN(o_mo), .O_MASTER_OUT_PIN_OE_N(mo_oe_n),
		.I_MASTER_IN_PIN(miso), .O_MASTER_IN_PIN(o_mi), .O_MASTER_IN_PIN_OE_N(mi_oe_n),
		.I_SLAVE_SELECT_PIN_N(ss_n), .O_SLAVE_SELECT_PIN_N(o_ss),
		.O_SLAVE_SELECT_PIN_OE_N(ss_oe_n));
	function void chk(string s, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endfunction
	task end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Ready is sampled 1 ns after an edge, so the word is taken at the next edge.
	task automatic push_tx(input logic [7:0] d);
		int n;
		n = 0;
		tick(1);
		txd = d;
		txv = 1'b1;
		while (txr !== 1'b1 && n < 2000)
		begin
			tick(1);
			n++;
		end
		tick(1);
		txv = 1'b0;
	endtask
	always @(posedge clk)
	begin
		if (ovr === 1'b1)
			n_ovr++;
		if (rxv === 1'b1 && rxr === 1'b1)
		begin
			if (q.size() == 0)
			begin
				n_errors++;
				$display("[ERR] rx_data expected none seen %h", rxd);
			end
			else
				chk("rx_data", q.pop_front(), rxd);
		end
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	initial
	begin
		seed = 91328;
		tick(4);
		rst_n = 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			{clock_polarity, clock_phase, lsb} = 3'(k);
			a = 8'($random(seed));
			m = 8'($random(seed));
			push_tx(a);
			q.push_back(m);
			far.xfer(m, r);
			chk("far_rx", a, r);
		end
		tick(20);
		chk("rx_left", 8'h00, 8'(q.size()));
		// Hold the receiver off: two words fit, the third is dropped.
		rxr = 1'b0;
		a = 8'($random(seed));
		b = 8'($random(seed));
		push_tx(a);
		tick(1);
		chk("tx_ready", 8'h00, {7'h00, txr});
		for (int k = 0; k < 3; k++)
		begin
			m = 8'($random(seed));
			if (k < 2)
				q.push_back(m);
			fork
				far.xfer(m, r);
				if (k == 0)
					push_tx(b);
			join
			chk("far_rx", (k == 0) ? a : (k == 1) ? b : 8'h00, r);
		end
		chk("overrun", 8'h01, 8'(n_ovr));
		rxr = 1'b1;
		tick(20);
		chk("rx_left", 8'h00, 8'(q.size()));
		en = 1'b0;
		tick(3);
		chk("oe_off", 8'h0F, {4'h0, sck_oe_n, mo_oe_n, mi_oe_n, ss_oe_n});
		en = 1'b1;
		swire = 1'b1;
		tick(3);
		chk("oe_wire", 8'h03, {6'h00, mo_oe_n, mi_oe_n});
		swire = 1'b0;
		mst = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			{mfe, clock_polarity} = 2'(k);
			select_output_enable = 1'b1;
			tick(3);
			chk("idle_sck", {7'h00, clock_polarity}, {7'h00, o_sck});
			chk("sck_oe", 8'h00, {7'h00, sck_oe_n});
			chk("ss_pin", {6'h00, ~mfe, 1'b1}, {6'h00, ss_oe_n, o_ss});
		end
		// As master nobody drives the data-in line, so its pull-up gives all ones.
		a = 8'($random(seed));
		push_tx(a);
		q.push_back(8'hFF);
		tick(4);
		chk("ss_out", 8'h01, {7'h00, busy & ~o_ss});
		tick(400);
		chk("rx_left", 8'h00, 8'(q.size()));
		chk("idle_busy", 8'h00, {7'h00, busy});
		end_of_test();
	end
endmodule // spi_master_slave_shifter_tb
